// ### core/rhd_params.svh
// register offsets, field positions, reset values and fixed coefficients
`ifndef RHD_PARAMS_SVH
`define RHD_PARAMS_SVH

`define RHD_ADDR_HB_CTRL     12'h41e
`define RHD_ADDR_NSR_MODE    12'h420
`define RHD_ADDR_NSR_TUNE    12'h422

`define RHD_HB_HP_BIT        7
`define RHD_HB_INSERT_BIT    0
`define RHD_NSR_EN_BIT       3
`define RHD_NSR_BADTW_BIT    7

`define RHD_RST_HB_CTRL      8'h01
`define RHD_RST_NSR_MODE     8'h08
`define RHD_RST_NSR_TUNE     8'h00

`define RHD_C_OUTER          12'h019
`define RHD_C_2              12'h02f
`define RHD_C_4              12'h05d
`define RHD_C_6              12'h0c2
`define RHD_C_8              12'h284
`define RHD_C_CENTRE         12'h400
`define RHD_HB_SHIFT         11

`define RHD_ATT_MUL          8'hb5
`define RHD_ATT_SHIFT        8

`define RHD_TW_MAX_NARROW    6'h3a
`define RHD_TW_MAX_WIDE      6'h2b
`define RHD_TW_STEP_PM       10'h005
`define RHD_HALF_NARROW_PM   10'h069
`define RHD_HALF_WIDE_PM     10'h08c
`define RHD_QUARTER_PM       10'h0fa

`endif

// ### core/rhd_pkg.sv
// types shared by the requantizer and half-band decimator
`default_nettype none
package rhd_pkg;
   typedef logic [7:0] rhd_reg_t;
   typedef enum logic [2:0] {RHD_PROF_NARROW, RHD_PROF_WIDE} rhd_profile_e;
endpackage : rhd_pkg
`default_nettype wire

// ### core/rhd_fifo.sv
// parameterised valid/ready fifo for the decimated sample stream
`default_nettype none
module rhd_fifo #(
   parameter int W     = 14,
   parameter int DEPTH = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0]             wp;
      logic [AW:0]             rp;
   } rhd_fifo_s;

   rhd_fifo_s r_reg;
   rhd_fifo_s r_next;
   logic      full;
   logic      empty;

   assign empty     = r_reg.wp == r_reg.rp;
   assign full      = (r_reg.wp[AW-1:0] == r_reg.rp[AW-1:0]) && (r_reg.wp[AW] != r_reg.rp[AW]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = r_reg.mem[r_reg.rp[AW-1:0]];

   always_comb begin
      r_next = r_reg;
      if (in_valid && !full) begin
         r_next.mem[r_reg.wp[AW-1:0]] = in_data;
         r_next.wp = r_reg.wp + 1'b1;
      end
      if (out_ready && !empty) begin
         r_next.rp = r_reg.rp + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
endmodule : rhd_fifo
`default_nettype wire

// ### core/rhd_requant_halfband.sv
// one channel: half-band decimator by two followed by noise shaping requantizer
`default_nettype none
`include "rhd_params.svh"

module rhd_requant_halfband #(
   parameter int SAMPLE_W   = 14,
   parameter int NSR_BITS   = 9,
   parameter int FIFO_DEPTH = 8,
   parameter bit CHANNEL    = 1'b0,
   parameter bit SLOW_GRADE = 1'b0
) (
   input  wire logic                  CLK_SYS,
   input  wire logic                  RST,
   input  wire logic                  REG_SEL_CH,
   input  wire logic [11:0]           REG_ADDR,
   input  wire rhd_pkg::rhd_reg_t     REG_WDATA,
   input  wire logic                  REG_WR,
   input  wire logic                  REG_RD,
   output rhd_pkg::rhd_reg_t          REG_RDATA,
   input  wire logic [SAMPLE_W-1:0]   SAMPLE_IN,
   input  wire logic                  SAMPLE_VALID,
   output logic                       SAMPLE_READY,
   output logic [SAMPLE_W-1:0]        OUT_DATA,
   output logic                       OUT_VALID,
   input  wire logic                  OUT_READY
);
   import rhd_pkg::*;

   localparam int TAPS  = 19;
   localparam int MID   = 9;
   localparam int ACC_W = SAMPLE_W + 14;
   localparam int DROP  = SAMPLE_W - NSR_BITS;
   localparam logic signed [ACC_W-1:0] SMAX = ACC_W'((1 << (SAMPLE_W - 1)) - 1);
   localparam logic signed [ACC_W-1:0] SMIN = -SMAX - ACC_W'(1);
   localparam logic [ACC_W-1:0]        LSB_MASK = ACC_W'((1 << DROP) - 1);

   typedef struct packed {
      rhd_reg_t                       hb_ctrl;
      rhd_reg_t                       nsr_mode;
      rhd_reg_t                       nsr_tune;
      rhd_reg_t                       rdata;
      logic [TAPS-1:0][SAMPLE_W-1:0]  taps;
      logic                           phase;
      logic                           hb_vld;
      logic [SAMPLE_W-1:0]            hb_y;
      logic [SAMPLE_W-1:0]            err;
   } rhd_state_s;

   rhd_state_s                    r_reg;
   rhd_state_s                    r_next;
   logic [TAPS-1:0][SAMPLE_W-1:0] tn;
   logic signed [SAMPLE_W:0]      pr [0:8];
   logic signed [SAMPLE_W:0]      ctr;
   logic signed [ACC_W-1:0]       acc;
   logic [SAMPLE_W-1:0]           hb_sum;
   logic signed [ACC_W-1:0]       att;
   logic signed [ACC_W-1:0]       v;
   logic signed [ACC_W-1:0]       q;
   logic [SAMPLE_W-1:0]           qs;
   logic signed [ACC_W-1:0]       e;
   logic [SAMPLE_W-1:0]           err_new;
   logic [SAMPLE_W-1:0]           fifo_in;
   logic                          fifo_rdy;
   logic                          nsr_en;
   logic                          hp_mode;
   logic                          dec_on;
   logic                          low_band;
   logic                          bad_tw;
   logic                          take;
   logic                          wr_own;
   logic [9:0]                    centre_pm;
   rhd_reg_t                      rd_mux;

   function automatic logic signed [ACC_W-1:0] mul_c(input logic signed [SAMPLE_W:0] s,
                                                     input logic [11:0] c);
      logic signed [ACC_W-1:0] se;
      logic signed [ACC_W-1:0] ce;
      se = ACC_W'(s);
      ce = ACC_W'($signed({1'b0, c}));
      mul_c = se * ce;
   endfunction : mul_c

   function automatic logic [SAMPLE_W-1:0] sat(input logic signed [ACC_W-1:0] a);
      if (a > SMAX) begin
         sat = SMAX[SAMPLE_W-1:0];
      end else if (a < SMIN) begin
         sat = SMIN[SAMPLE_W-1:0];
      end else begin
         sat = a[SAMPLE_W-1:0];
      end
   endfunction : sat

   assign nsr_en  = r_reg.nsr_mode[`RHD_NSR_EN_BIT];
   assign hp_mode = r_reg.hb_ctrl[`RHD_HB_HP_BIT];
   assign dec_on  = nsr_en && (!SLOW_GRADE || r_reg.hb_ctrl[`RHD_HB_INSERT_BIT]);
   assign wr_own  = REG_WR && (REG_SEL_CH == CHANNEL);
   assign take    = SAMPLE_VALID && SAMPLE_READY;
   // stall only while the decimated word waits for fifo room
   assign SAMPLE_READY = !r_reg.hb_vld || fifo_rdy;
   assign tn = {r_reg.taps[TAPS-2:0], SAMPLE_IN};
   assign REG_RDATA = r_reg.rdata;

   // band edge from tuning word, half widths
   always_comb begin
      centre_pm = 10'(r_reg.nsr_tune[5:0]) * `RHD_TW_STEP_PM;
      if (r_reg.nsr_mode[2:0] == 3'(RHD_PROF_WIDE)) begin
         centre_pm = centre_pm + `RHD_HALF_WIDE_PM;
      end else begin
         centre_pm = centre_pm + `RHD_HALF_NARROW_PM;
      end
      low_band = centre_pm < `RHD_QUARTER_PM;
   end

   // out-of-range words flagged, hardware keeps using them
   always_comb begin
      case (r_reg.nsr_mode[2:0])
         3'(RHD_PROF_NARROW): bad_tw = r_reg.nsr_tune[5:0] > `RHD_TW_MAX_NARROW;
         3'(RHD_PROF_WIDE):   bad_tw = r_reg.nsr_tune[5:0] > `RHD_TW_MAX_WIDE;
         default:             bad_tw = 1'b1;
      endcase
   end

   // symmetric pairs fold nineteen taps onto five multipliers plus centre
   always_comb begin
      for (int k = 0; k < 9; k++) begin
         pr[k] = $signed({tn[k][SAMPLE_W-1], tn[k]})
               + $signed({tn[TAPS-1-k][SAMPLE_W-1], tn[TAPS-1-k]});
      end
      ctr = $signed({tn[MID][SAMPLE_W-1], tn[MID]});
      // low-pass taps, odd pairs have no multiplier
      acc = mul_c(pr[0], `RHD_C_OUTER) - mul_c(pr[2], `RHD_C_2)
          + mul_c(pr[4], `RHD_C_4) - mul_c(pr[6], `RHD_C_6)
          + mul_c(pr[8], `RHD_C_8);
      // centre sign flip, selects the upper zones
      if (hp_mode) begin
         acc = acc - mul_c(ctr, `RHD_C_CENTRE);
      end else begin
         acc = acc + mul_c(ctr, `RHD_C_CENTRE);
      end
      hb_sum = sat(acc >>> `RHD_HB_SHIFT);
   end

   // 3 dB loss ahead of the requantizer
   always_comb begin
      // signed gain keeps the shift arithmetic for negative words
      att = (ACC_W'($signed(r_reg.hb_y)) * $signed(ACC_W'(`RHD_ATT_MUL))) >>> `RHD_ATT_SHIFT;
      // error feedback notch: dc for low bands, nyquist for high bands
      if (low_band) begin
         v = att - ACC_W'($signed(r_reg.err));
      end else begin
         v = att + ACC_W'($signed(r_reg.err));
      end
      q  = v & ~LSB_MASK;
      qs = sat(q) & ~LSB_MASK[SAMPLE_W-1:0];
      e  = ACC_W'($signed(qs)) - v;
      // a clipped word would feed back a huge error, so drop it
      if (ACC_W'($signed(qs)) != q) begin
         err_new = '0;
      end else begin
         err_new = e[SAMPLE_W-1:0];
      end
      fifo_in = nsr_en ? qs : r_reg.hb_y;
   end

   always_comb begin
      rd_mux = '0;
      if (REG_SEL_CH == CHANNEL) begin
         case (REG_ADDR)
            `RHD_ADDR_HB_CTRL:  rd_mux = r_reg.hb_ctrl;
            `RHD_ADDR_NSR_MODE: rd_mux = {bad_tw, r_reg.nsr_mode[6:0]};
            `RHD_ADDR_NSR_TUNE: rd_mux = {2'b00, r_reg.nsr_tune[5:0]};
            default:            rd_mux = '0;
         endcase
      end
   end

   always_comb begin
      r_next = r_reg;
      if (REG_RD) begin
         r_next.rdata = rd_mux;
      end
      if (wr_own) begin
         case (REG_ADDR)
            `RHD_ADDR_HB_CTRL:  r_next.hb_ctrl  = REG_WDATA;
            `RHD_ADDR_NSR_MODE: r_next.nsr_mode = {1'b0, REG_WDATA[6:0]};
            `RHD_ADDR_NSR_TUNE: r_next.nsr_tune = {2'b00, REG_WDATA[5:0]};
            default:            r_next.nsr_tune = r_reg.nsr_tune;
         endcase
      end
      if (r_reg.hb_vld && fifo_rdy) begin
         r_next.hb_vld = 1'b0;
         if (nsr_en) begin
            r_next.err = err_new;
         end
      end
      if (take) begin
         r_next.taps = tn;
         r_next.phase = dec_on ? ~r_reg.phase : 1'b0;
         if (!dec_on || r_reg.phase) begin
            r_next.hb_vld = 1'b1;
            r_next.hb_y   = dec_on ? hb_sum : SAMPLE_IN;
         end
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         r_reg          <= '0;
         r_reg.hb_ctrl  <= `RHD_RST_HB_CTRL;
         r_reg.nsr_mode <= `RHD_RST_NSR_MODE;
         r_reg.nsr_tune <= `RHD_RST_NSR_TUNE;
      end else begin
         r_reg <= r_next;
      end
   end

   rhd_fifo #(
      .W     (SAMPLE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_out_fifo (
      .clk       (CLK_SYS),
      .rst       (RST),
      .in_data   (fifo_in),
      .in_valid  (r_reg.hb_vld),
      .in_ready  (fifo_rdy),
      .out_data  (OUT_DATA),
      .out_valid (OUT_VALID),
      .out_ready (OUT_READY)
   );

   // helper: only the centre tap of the shifted line is nonzero
   logic only_ctr;
   always_comb begin
      only_ctr = 1'b1;
      for (int k = 0; k < TAPS; k++) begin
         if (k != MID && tn[k] != '0) begin
            only_ctr = 1'b0;
         end
      end
   end

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RST);

   AST_DECIM_PAIR: assert property (
      take && dec_on && r_reg.phase |=> r_reg.hb_vld ##0 !r_reg.phase)
      else $error("second sample of a pair made no output");
   AST_DECIM_SKIP: assert property (
      take && dec_on && !r_reg.phase && !r_reg.hb_vld |=> !r_reg.hb_vld ##0 r_reg.phase)
      else $error("first sample of a pair produced output");
   AST_TAP_SHIFT: assert property (
      take |=> r_reg.taps[1] == $past(r_reg.taps[0]) && r_reg.taps[0] == $past(SAMPLE_IN))
      else $error("delay line did not shift by one");
   AST_LP_CENTRE: assert property (
      take && dec_on && r_reg.phase && !hp_mode && only_ctr
      |=> r_reg.hb_y == SAMPLE_W'($signed(r_reg.taps[MID]) >>> 1))
      else $error("low-pass centre tap gain wrong");
   AST_HP_CENTRE: assert property (
      take && dec_on && r_reg.phase && hp_mode && only_ctr && tn[MID][SAMPLE_W-1] == 1'b0
      |=> r_reg.hb_y == SAMPLE_W'((-$signed(r_reg.taps[MID])) >>> 1))
      else $error("high-pass centre tap not negated");
   AST_MODE_WRITE: assert property (
      wr_own && REG_ADDR == `RHD_ADDR_HB_CTRL |=> hp_mode == $past(REG_WDATA[7]))
      else $error("filter mode bit not written");
   AST_GRADE_PATH: assert property (
      nsr_en && !SLOW_GRADE |-> dec_on)
      else $error("decimator bypassed on a fast grade");
   AST_OTHER_CHAN: assert property (
      REG_WR && REG_SEL_CH != CHANNEL
      |=> $stable(r_reg.hb_ctrl) && $stable(r_reg.nsr_mode) && $stable(r_reg.nsr_tune))
      else $error("write to other channel changed settings");
   AST_RESET_EN: assert property (
      $past(RST) |-> nsr_en)
      else $error("requantizer not enabled after reset");
   AST_TW_RANGE: assert property (
      REG_RD && REG_SEL_CH == CHANNEL && REG_ADDR == `RHD_ADDR_NSR_MODE
      && r_reg.nsr_mode[2:0] == 3'b000 && r_reg.nsr_tune[5:0] == 6'h3b
      |=> REG_RDATA[`RHD_NSR_BADTW_BIT])
      else $error("narrow tuning word 59 not flagged");

   COV_DECIM_OUT: cover property (take && dec_on && r_reg.phase ##1 fifo_rdy);
   COV_HP_OUT:    cover property (hp_mode && take && dec_on && r_reg.phase);
   COV_FIFO_FULL: cover property (r_reg.hb_vld && !fifo_rdy);
endmodule : rhd_requant_halfband
`default_nettype wire

// ### test/rhd_sink_model.sv
// framer-side sink model: pops words from the block, stalls on request
`default_nettype none
module rhd_sink_model #(
   parameter int W = 14
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] out_data,
   input  wire logic         out_valid,
   output logic              out_ready,
   input  wire logic         stall,
   output logic              got,
   output logic [W-1:0]      got_data
);
   timeunit 1ns;
   timeprecision 1ps;
   // ready follows stall directly so a stall takes effect on the next edge
   assign out_ready = !stall;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         got      <= 1'b0;
         got_data <= '0;
      end else begin
         got      <= out_valid && out_ready;
         got_data <= out_data;
      end
   end
endmodule : rhd_sink_model
`default_nettype wire

// ### test/rhd_requant_halfband_tb_top.sv
// self-checking bench for one requantizer and half-band channel
`default_nettype none
module rhd_requant_halfband_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rhd_pkg::*;
   logic              clk_sys;
   logic              rst;
   logic              sel_ch;
   logic [11:0]       addr;
   rhd_reg_t          wdata;
   logic              wr;
   logic              rd;
   rhd_reg_t          rdata;
   logic [13:0]       s_in;
   logic              s_valid;
   logic              s_ready;
   logic [13:0]       o_data;
   logic              o_valid;
   logic              o_ready;
   logic              stall;
   logic              got;
   logic [13:0]       got_data;
   logic [31:0]       seed;
   logic [13:0]       exp_q[$];
   int                bad_count;
   int                check_count;
   logic [13:0]       d_in;
   int                hist_m [19];
   int                err_m;
   bit                ph_m;

   rhd_requant_halfband dut_u (
      .CLK_SYS(clk_sys), .RST(rst), .REG_SEL_CH(sel_ch), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
      .SAMPLE_IN(s_in), .SAMPLE_VALID(s_valid), .SAMPLE_READY(s_ready),
      .OUT_DATA(o_data), .OUT_VALID(o_valid), .OUT_READY(o_ready));
   rhd_sink_model sink_u (
      .clk(clk_sys), .rst(rst), .out_data(o_data), .out_valid(o_valid),
      .out_ready(o_ready), .stall(stall), .got(got), .got_data(got_data));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
   endfunction : lfsr

   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic chk_reg(input rhd_reg_t got_v, input rhd_reg_t exp_v);
      check_count++;
      if (got_v !== exp_v) begin
         bad_count++;
         $display("Error at %0t reg got %h exp %h", $time, got_v, exp_v);
      end
   endtask : chk_reg

   task automatic chk_word(input logic [13:0] got_v, input logic [13:0] exp_v);
      check_count++;
      if (got_v !== exp_v) begin
         bad_count++;
         $display("Error at %0t word got %h exp %h", $time, got_v, exp_v);
      end
   endtask : chk_word

   // rule taps, centre flip, 3 dB loss, low-band error feedback
   task automatic model_push(input logic [13:0] x, input logic hp);
      int c [19] = '{25,0,-47,0,93,0,-194,0,644,1024,644,0,-194,0,93,0,-47,0,25};
      int acc;
      int y;
      int q;
      int v;
      acc = 0;
      for (int k = 18; k > 0; k--) begin
         hist_m[k] = hist_m[k-1];
      end
      hist_m[0] = int'($signed(x));
      if (ph_m) begin
         for (int k = 0; k < 19; k++) begin
            acc += c[k] * hist_m[k];
         end
         if (hp) begin
            acc -= 2048 * hist_m[9];
         end
         y = acc >>> 11;
         y = (y > 8191) ? 8191 : ((y < -8192) ? -8192 : y);
         v = ((y * 181) >>> 8) - err_m;
         q = ((v & ~31) > 8191) ? 8160 : (v & ~31);
         err_m = (q == (v & ~31)) ? q - v : 0;
         exp_q.push_back(q[13:0]);
      end
      ph_m = !ph_m;
   endtask : model_push

   task automatic reg_wr(input logic ch, input logic [11:0] a, input rhd_reg_t d);
      sel_ch <= ch;
      addr   <= a;
      wdata  <= d;
      wr     <= 1'b1;
      @(posedge clk_sys);
      wr     <= 1'b0;
      @(posedge clk_sys);
   endtask : reg_wr

   task automatic reg_rd(input logic ch, input logic [11:0] a, input rhd_reg_t e);
      sel_ch <= ch;
      addr   <= a;
      rd     <= 1'b1;
      @(posedge clk_sys);
      rd     <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk_reg(rdata, e);
   endtask : reg_rd

   // holds valid and data until an edge that sees ready high
   task automatic send(input logic [13:0] d);
      logic ok;
      int   n;
      s_in    <= d;
      s_valid <= 1'b1;
      n = 0;
      do begin
         @(negedge clk_sys);
         ok = s_ready;
         @(posedge clk_sys);
         n++;
      end while (ok !== 1'b1 && n < 200);
      if (n >= 200) begin
         bad_count++;
      end
   endtask : send

   always @(negedge clk_sys) begin
      if (got === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk_word(got_data, 14'h3fff);
         end else begin
            chk_word(got_data, exp_q.pop_front());
         end
      end
   end

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   initial begin
      #2000000;
      bad_count++;
      stop_test();
   end

   initial begin
      rst = 1'b1; sel_ch = 1'b0; addr = 12'h000; wdata = 8'h00; wr = 1'b0;
      rd = 1'b0; s_in = 14'h0000; s_valid = 1'b0; stall = 1'b0; seed = 32'h50360dbf;
      bad_count = 0;
      check_count = 0;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      reg_rd(1'b0, 12'h41e, 8'h01);
      reg_rd(1'b0, 12'h420, 8'h08);
      reg_rd(1'b0, 12'h422, 8'h00);
      // zeros, an impulse and a random burst through the enabled path, both modes
      for (int m = 0; m < 2; m++) begin
         if (m == 1) begin
            reg_wr(1'b0, 12'h41e, 8'h81);
         end
         // impulse sits alone in the line at take 13, so the centre checks fire
         for (int i = 0; i < 26; i++) begin
            seed = lfsr(seed);
            d_in = (i == 4) ? 14'h0123 : ((i >= 14 && i < 20) ? seed[13:0] : 14'h0000);
            send(d_in);
            model_push(d_in, m == 1);
         end
         s_valid <= 1'b0;
         repeat (10) @(posedge clk_sys);
         chk_reg({7'h00, exp_q.size() == 0}, 8'h01);
      end
      reg_rd(1'b0, 12'h41e, 8'h81);
      reg_wr(1'b1, 12'h41e, 8'h00);
      reg_rd(1'b0, 12'h41e, 8'h81);
      reg_rd(1'b1, 12'h41e, 8'h00);
      reg_rd(1'b0, 12'h421, 8'h00);
      // settings change only while no stream is relied on
      reg_wr(1'b0, 12'h422, 8'hff);
      reg_rd(1'b0, 12'h422, 8'h3f);
      reg_wr(1'b0, 12'h420, 8'h81);
      reg_rd(1'b0, 12'h420, 8'h81);
      reg_wr(1'b0, 12'h422, 8'h2b);
      reg_rd(1'b0, 12'h420, 8'h01);
      reg_wr(1'b0, 12'h420, 8'h00);
      reg_wr(1'b0, 12'h422, 8'h3a);
      reg_rd(1'b0, 12'h420, 8'h00);
      reg_wr(1'b0, 12'h422, 8'h3b);
      reg_rd(1'b0, 12'h420, 8'h80);
      // requantizer off: raw words, random sink stalls
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         stall <= seed[3];
         exp_q.push_back(seed[13:0]);
         send(seed[13:0]);
         // idle cycle lets the sink drain, else stalls pile up until refusal
         s_valid <= 1'b0;
         stall   <= 1'b0;
         @(posedge clk_sys);
      end
      s_valid <= 1'b0;
      stall <= 1'b1;
      repeat (40) @(posedge clk_sys);
      stall <= 1'b0;
      repeat (20) @(posedge clk_sys);
      // fill fifo and held word with sink stalled, then check refusal
      stall <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         exp_q.push_back(14'h0100 + 14'(i));
         send(14'h0100 + 14'(i));
      end
      s_in <= 14'h0109;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk_reg({7'h00, s_ready}, 8'h00);
      stall <= 1'b0;
      exp_q.push_back(14'h0109);
      send(14'h0109);
      s_valid <= 1'b0;
      repeat (30) @(posedge clk_sys);
      chk_reg(8'(exp_q.size()), 8'h00);
      chk_reg({7'h00, o_valid}, 8'h00);
      stop_test();
   end
endmodule : rhd_requant_halfband_tb_top
`default_nettype wire
